// ===== rtl/bcs_top.sv
// Two breaker close synchronism check stages behind a classic Wishbone slave.
// Summary of operation
// - Two independent stages cover three voltages.
// - Voltage and/or frequency-phase criteria selectable.
// - Below dead limit means side dead.
// - Above live limit means side live.
// - Voltage check matches selected dead/live combination.
// - Frequency criterion needs both live, limits.
// - Zero mode closes early by closing time.
// - Window mode closes when angle inside.
// - Close command starts check cycle only.
// - Request high until sync or timeout.
// - Timeout gives fixed 200 ms fail pulse.
// - Sync issues internal close to breaker.
// - OK high while conditions hold.
// - Bypass declares synchronism always.
// - Request, OK, fail go to matrix.
// - Code letters: reference then comparison side.
// - Mode off drops frequency-phase criteria.
// - Check only when breaker selected.
// Assumes a Wishbone classic master on clk_i and measurement logic on the same clock.
`timescale 1ns/100ps
`include "bcs_map.svh"
module bcs_top
    import bcs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             err_o,
    input  wire logic [1:0]  close_cmd_i,
    input  wire logic [1:0]  bypass_i,
    input  wire bcs_meas_t   meas0_i,
    input  wire bcs_meas_t   meas1_i,
    output logic [1:0]       req_o,
    output logic [1:0]       ok_o,
    output logic [1:0]       fail_o,
    output logic [3:0]       close_cb_o
);
    logic [31:0] ctrl_ff [2];
    logic [19:0] tmo_ff  [2];
    logic [9:0]  adv_ff  [2];
    logic [15:0] tick_ff;
    logic        tick;
    logic [1:0]  cmd_ff;
    logic        ack_ff;
    logic        err_ff;
    logic        hit;
    logic        req;
    bcs_cfg_t    cfg [2];
    bcs_out_t    sout [2];
    bcs_meas_t   meas [2];

    // ============================================================
    // Millisecond tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_ff <= 16'h0000;
        end else if (tick_ff == 16'((`BCS_TICK_CYC) - 1)) begin
            tick_ff <= 16'h0000;
        end else begin
            tick_ff <= tick_ff + 16'h0001;
        end
    end
    assign tick = tick_ff == 16'((`BCS_TICK_CYC) - 1);

    // ============================================================
    // Wishbone slave, one wait state then ack; unmapped addresses answer err.
    assign req = cyc_i && stb_i && !ack_ff && !err_ff;
    always_comb begin
        hit = (adr_i == `BCS_ADR_CTRL0) || (adr_i == `BCS_ADR_CTRL1) || (adr_i == `BCS_ADR_TMO0)
           || (adr_i == `BCS_ADR_TMO1) || (adr_i == `BCS_ADR_ADV0) || (adr_i == `BCS_ADR_ADV1)
           || (adr_i == `BCS_ADR_STAT) || (adr_i == `BCS_ADR_CMD);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            ack_ff <= req && hit;
            err_ff <= req && !hit;
        end
    end
    assign ack_o = ack_ff;
    assign err_o = err_ff;

    function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : bmerge

    logic wr;
    assign wr = req && hit && we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int k = 0; k < 2; k++) begin
                ctrl_ff[k] <= `BCS_CTL_RST;
                tmo_ff[k]  <= `BCS_TMO_RST;
                adv_ff[k]  <= `BCS_ADV_RST;
            end
        end else if (wr) begin
            if (adr_i == `BCS_ADR_CTRL0) begin
                ctrl_ff[0] <= bmerge(ctrl_ff[0], dat_i, sel_i);
            end else if (adr_i == `BCS_ADR_CTRL1) begin
                ctrl_ff[1] <= bmerge(ctrl_ff[1], dat_i, sel_i);
            end else if (adr_i == `BCS_ADR_TMO0) begin
                tmo_ff[0] <= 20'(bmerge({12'h000, tmo_ff[0]}, dat_i, sel_i));
            end else if (adr_i == `BCS_ADR_TMO1) begin
                tmo_ff[1] <= 20'(bmerge({12'h000, tmo_ff[1]}, dat_i, sel_i));
            end else if (adr_i == `BCS_ADR_ADV0) begin
                adv_ff[0] <= 10'(bmerge({22'h000000, adv_ff[0]}, dat_i, sel_i));
            end else if (adr_i == `BCS_ADR_ADV1) begin
                adv_ff[1] <= 10'(bmerge({22'h000000, adv_ff[1]}, dat_i, sel_i));
            end
        end
    end

    // Software close request pulse per stage, alongside the close command pins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_ff <= 2'b00;
        end else if (wr && adr_i == `BCS_ADR_CMD && sel_i[0]) begin
            cmd_ff <= dat_i[1:0];
        end else begin
            cmd_ff <= 2'b00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && hit && !we_i) begin
            if (adr_i == `BCS_ADR_CTRL0) begin
                dat_o <= {23'h000000, ctrl_ff[0][8:0]};
            end else if (adr_i == `BCS_ADR_CTRL1) begin
                dat_o <= {23'h000000, ctrl_ff[1][8:0]};
            end else if (adr_i == `BCS_ADR_TMO0) begin
                dat_o <= {12'h000, tmo_ff[0]};
            end else if (adr_i == `BCS_ADR_TMO1) begin
                dat_o <= {12'h000, tmo_ff[1]};
            end else if (adr_i == `BCS_ADR_ADV0) begin
                dat_o <= {22'h000000, adv_ff[0]};
            end else if (adr_i == `BCS_ADR_ADV1) begin
                dat_o <= {22'h000000, adv_ff[1]};
            end else if (adr_i == `BCS_ADR_STAT) begin
                dat_o <= {26'h0000000, fail_o, ok_o, req_o};
            end else begin
                dat_o <= 32'h0000_0000;
            end
        end
    end

    // ============================================================
    // Stages
    assign meas[0] = meas0_i;
    assign meas[1] = meas1_i;

    for (genvar g = 0; g < 2; g++) begin : g_stage
        always_comb begin
            cfg[g].vmode   = ctrl_ff[g][`BCS_CTL_VMODE_MSB:`BCS_CTL_VMODE_LSB];
            cfg[g].smode   = bcs_smode_t'(ctrl_ff[g][`BCS_CTL_SMODE_MSB:`BCS_CTL_SMODE_LSB]);
            cfg[g].cb_sel  = ctrl_ff[g][`BCS_CTL_CBSEL_MSB:`BCS_CTL_CBSEL_LSB];
            cfg[g].vchk_en = ctrl_ff[g][`BCS_CTL_VCHK_EN];
            cfg[g].fchk_en = ctrl_ff[g][`BCS_CTL_FCHK_EN];
            cfg[g].tmo_ms  = tmo_ff[g];
            cfg[g].adv_ms  = adv_ff[g];
        end

        bcs_stage bcs_stage_i (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .tick_i      (tick),
            .close_cmd_i (close_cmd_i[g] | cmd_ff[g]),
            .bypass_i    (bypass_i[g]),
            .meas_i      (meas[g]),
            .cfg_i       (cfg[g]),
            .out_o       (sout[g])
        );

        assign req_o[g]            = sout[g].req;
        assign ok_o[g]             = sout[g].ok;
        assign fail_o[g]           = sout[g].fail;
        assign close_cb_o[g*2 +: 2] = sout[g].close_cb;
    end
endmodule : bcs_top

// ===== include/bcs_map.svh
// Offsets, field positions, reset values and timing counts of the close check stages.
// Assumes inclusion by bcs_pkg and the design modules by bare name.
`ifndef BCS_MAP_SVH
`define BCS_MAP_SVH

// ============================================================
// Register offsets (byte addresses)
`define BCS_ADR_CTRL0      8'h00
`define BCS_ADR_CTRL1      8'h04
`define BCS_ADR_TMO0       8'h08
`define BCS_ADR_TMO1       8'h0c
`define BCS_ADR_ADV0       8'h10
`define BCS_ADR_ADV1       8'h14
`define BCS_ADR_STAT       8'h18
`define BCS_ADR_CMD        8'h1c

// ============================================================
// Control register fields
`define BCS_CTL_VMODE_LSB  0
`define BCS_CTL_VMODE_MSB  2
`define BCS_CTL_SMODE_LSB  3
`define BCS_CTL_SMODE_MSB  4
`define BCS_CTL_CBSEL_LSB  5
`define BCS_CTL_CBSEL_MSB  6
`define BCS_CTL_VCHK_EN    7
`define BCS_CTL_FCHK_EN    8
`define BCS_CTL_RST        32'h0000_0000

// ============================================================
// Voltage check mode mask bits
`define BCS_VM_BOTH_DEAD   0
`define BCS_VM_RDEAD_CLIVE 1
`define BCS_VM_RLIVE_CDEAD 2

// ============================================================
// Timing
`define BCS_CLK_HZ         40000000
`define BCS_TICK_MS        1
`define BCS_TICK_CYC       ((`BCS_CLK_HZ / 1000) * `BCS_TICK_MS)
`define BCS_FAIL_MS        16'h00c8
`define BCS_TMO_RST        20'h003e8
`define BCS_ADV_RST        10'h028

`endif

// ===== include/bcs_pkg.sv
// Types shared by the close check stages.
// Assumes bcs_map.svh is on the include path.
package bcs_pkg;
    `include "bcs_map.svh"

    typedef enum logic [1:0] {
        BCS_SM_OFF,
        BCS_SM_WINDOW,
        BCS_SM_ZERO
    } bcs_smode_t;

    typedef struct packed {
        logic ref_dead;
        logic ref_live;
        logic cmp_dead;
        logic cmp_live;
        logic du_ok;
        logic df_ok;
        logic ang_ok;
        logic zero_adv;
    } bcs_meas_t;

    typedef struct packed {
        logic [2:0] vmode;
        bcs_smode_t smode;
        logic [1:0] cb_sel;
        logic       vchk_en;
        logic       fchk_en;
        logic [19:0] tmo_ms;
        logic [9:0]  adv_ms;
    } bcs_cfg_t;

    typedef struct packed {
        logic       req;
        logic       ok;
        logic       fail;
        logic [1:0] close_cb;
    } bcs_out_t;
endpackage : bcs_pkg

// ===== rtl/bcs_stage.sv
// One synchronism check stage: qualification, request, timeout and fail pulse.
// Assumes measurement flags synchronous to clk_i and a one-cycle millisecond tick.
`timescale 1ns/100ps
`include "bcs_map.svh"
module bcs_stage
    import bcs_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire logic      tick_i,
    input  wire logic      close_cmd_i,
    input  wire logic      bypass_i,
    input  wire bcs_meas_t meas_i,
    input  wire bcs_cfg_t  cfg_i,
    output bcs_out_t       out_o
);
    typedef enum logic [1:0] {
        BCS_IDLE,
        BCS_WAIT
    } bcs_st_t;

    bcs_st_t     st_ff;
    logic [19:0] tmo_ff;
    logic [15:0] fail_ff;
    logic [9:0]  adv_ff;
    logic        v_ok;
    logic        f_ok;
    logic        moment;
    logic        sync_ok;
    logic        checked;
    logic        adv_done;

    // ============================================================
    // Qualification
    always_comb begin
        v_ok = (cfg_i.vmode[`BCS_VM_BOTH_DEAD] && meas_i.ref_dead && meas_i.cmp_dead)
            || (cfg_i.vmode[`BCS_VM_RDEAD_CLIVE] && meas_i.ref_dead && meas_i.cmp_live)
            || (cfg_i.vmode[`BCS_VM_RLIVE_CDEAD] && meas_i.ref_live && meas_i.cmp_dead);
        f_ok = meas_i.ref_live && meas_i.cmp_live && meas_i.du_ok && meas_i.df_ok && meas_i.ang_ok;
        if (cfg_i.smode == BCS_SM_OFF) begin
            f_ok = 1'b0;
        end
    end

    // Either criterion alone, or both required when both are enabled and the sync mode is not off.
    always_comb begin
        if (bypass_i) begin
            sync_ok = 1'b1;
        end else if (cfg_i.vchk_en && cfg_i.fchk_en && cfg_i.smode != BCS_SM_OFF) begin
            sync_ok = v_ok && f_ok;
        end else if (cfg_i.vchk_en) begin
            sync_ok = v_ok;
        end else if (cfg_i.fchk_en) begin
            sync_ok = f_ok;
        end else begin
            sync_ok = 1'b0;
        end
    end

    assign checked  = cfg_i.cb_sel != 2'b00;
    assign adv_done = adv_ff == 10'h000;

    // Zero mode waits for the advance indication plus a configured lead while f_ok holds; otherwise, and in window mode, closes at once.
    always_comb begin
        if (bypass_i || !f_ok) begin
            moment = sync_ok;
        end else if (cfg_i.smode == BCS_SM_ZERO) begin
            moment = sync_ok && meas_i.zero_adv && adv_done;
        end else begin
            moment = sync_ok;
        end
    end

    // ============================================================
    // Request sequencing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= BCS_IDLE;
        end else begin
            case (st_ff)
                BCS_IDLE: begin
                    if (close_cmd_i && checked && !moment) begin
                        st_ff <= BCS_WAIT;
                    end
                end
                BCS_WAIT: begin
                    if (moment || (tick_i && tmo_ff <= 20'h00001)) begin
                        st_ff <= BCS_IDLE;
                    end
                end
                default: st_ff <= BCS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmo_ff <= 20'h00000;
        end else if (st_ff == BCS_IDLE) begin
            tmo_ff <= cfg_i.tmo_ms;
        end else if (tick_i && tmo_ff != 20'h00000) begin
            tmo_ff <= tmo_ff - 20'h00001;
        end
    end

    // Advance counter rearms whenever the advance indication drops.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adv_ff <= 10'h000;
        end else if (!meas_i.zero_adv) begin
            adv_ff <= cfg_i.adv_ms;
        end else if (tick_i && !adv_done) begin
            adv_ff <= adv_ff - 10'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fail_ff <= 16'h0000;
        end else if (st_ff == BCS_WAIT && !moment && tick_i && tmo_ff <= 20'h00001) begin
            fail_ff <= `BCS_FAIL_MS;
        end else if (tick_i && fail_ff != 16'h0000) begin
            fail_ff <= fail_ff - 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_o <= '0;
        end else begin
            out_o.req  <= (st_ff == BCS_WAIT && !moment) || (st_ff == BCS_IDLE && close_cmd_i && checked && !moment);
            out_o.ok   <= sync_ok;
            out_o.fail <= fail_ff != 16'h0000;
            if ((st_ff == BCS_WAIT && moment) || (st_ff == BCS_IDLE && close_cmd_i && (moment || !checked))) begin
                out_o.close_cb <= checked ? cfg_i.cb_sel : 2'b11;
            end else begin
                out_o.close_cb <= 2'b00;
            end
        end
    end
endmodule : bcs_stage

// ===== verification/bcs_top_props.sv
// Port checks for the close check top.
// Assumes one clock and a synchronous reset.
`timescale 1ns/100ps
module bcs_top_props
    import bcs_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       cyc_i,
    input  wire logic       stb_i,
    input  wire logic [1:0] bypass_i,
    input  wire logic       ack_o,
    input  wire logic       err_o,
    input  wire logic [1:0] req_o,
    input  wire logic [1:0] ok_o,
    input  wire logic [1:0] fail_o,
    input  wire logic [3:0] close_cb_o
);
    // ==========
    // Properties
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    AST_ACK_ONE: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    AST_ANSWER: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
        else $error("request not answered next cycle");
    AST_ACK_ERR: assert property (!(ack_o && err_o))
        else $error("ack and err together");
    AST_NO_REQ: assert property (ack_o || err_o |-> $past(cyc_i && stb_i))
        else $error("answer without request");
    AST_REQ_END: assert property ($fell(req_o[0]) |-> ##[0:1] (close_cb_o[1:0] != 2'b00 || fail_o[0]))
        else $error("request ended without close or fail");
    AST_CLOSE_PULSE: assert property (close_cb_o[1:0] != 2'b00 |=> close_cb_o[1:0] == 2'b00)
        else $error("close longer than one cycle");
    AST_FAIL_CAUSE: assert property ($rose(fail_o[0]) |-> $past(req_o[0]) || $past(req_o[0], 2))
        else $error("fail without request");
    AST_FAIL_LEN: assert property ($rose(fail_o[0]) |=> fail_o[0] [*8])
        else $error("fail pulse too short");
    AST_BYPASS: assert property (bypass_i[0] |=> ok_o[0])
        else $error("bypass without ok");
endmodule : bcs_top_props

bind bcs_top bcs_top_props bcs_top_props_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .bypass_i(bypass_i), .ack_o(ack_o), .err_o(err_o), .req_o(req_o), .ok_o(ok_o), .fail_o(fail_o),
    .close_cb_o(close_cb_o));

// ===== verification/bcs_far_model.sv
// Far side: object control giving close commands, and the measurement feed.
// Assumes requests from the bench on clk_i; outputs change at rising edges only.
`timescale 1ns/100ps
module bcs_far_model
    import bcs_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic [1:0] go_i,
    input  wire bcs_meas_t  meas_i,
    output logic [1:0]      close_cmd_o,
    output bcs_meas_t       meas0_o,
    output bcs_meas_t       meas1_o
);
    // ==========
    // Object control
    // A held go gives a pulse every second cycle, though a level would restart the stage as well, since idle starts on close_cmd_i high.
    always_ff @(posedge clk_i) begin
        close_cmd_o <= go_i & ~close_cmd_o;
    end
    // ==========
    // Measurement feed
    always_ff @(posedge clk_i) begin
        meas0_o <= meas_i;
        meas1_o <= meas_i;
    end
endmodule : bcs_far_model

// ===== verification/test_bcs_top.sv
// Self-checking bench for the close check top.
// Assumes bcs_pkg and bcs_map.svh; fail timing is seen only at its start.
`timescale 1ns/100ps
`include "bcs_map.svh"
module test_bcs_top;
    import bcs_pkg::*;
    typedef struct packed {
        logic [8:0] ctl;
        logic [7:0] meas;
        logic       byp;
        logic       ok;
    } bcs_row_t;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        err_o;
    logic [1:0]  go = 2'b00;
    logic [1:0]  bypass_i = 2'b00;
    bcs_meas_t   meas_set = 8'h00;
    logic [1:0]  close_cmd;
    bcs_meas_t   meas0;
    bcs_meas_t   meas1;
    logic [1:0]  req_o;
    logic [1:0]  ok_o;
    logic [1:0]  fail_o;
    logic [3:0]  close_cb_o;
    logic [31:0] rq;
    logic        re;
    int          failures = 0;
    int          cmp_count = 0;
    bcs_row_t    rows[10] = '{'{9'h0a1, 8'ha0, 1'b0, 1'b1}, '{9'h0a1, 8'h90, 1'b0, 1'b0},
        '{9'h0a2, 8'h90, 1'b0, 1'b1}, '{9'h0a4, 8'h60, 1'b0, 1'b1}, '{9'h0a4, 8'h90, 1'b0, 1'b0},
        '{9'h0a6, 8'h60, 1'b0, 1'b1}, '{9'h128, 8'h5e, 1'b0, 1'b1}, '{9'h128, 8'h5c, 1'b0, 1'b0},
        '{9'h1a1, 8'ha0, 1'b0, 1'b1}, '{9'h128, 8'h9c, 1'b1, 1'b1}};
    always #12.5 clk_i = ~clk_i;
    bcs_far_model bcs_far_model_i (.clk_i(clk_i), .go_i(go), .meas_i(meas_set), .close_cmd_o(close_cmd),
        .meas0_o(meas0), .meas1_o(meas1));
    bcs_top bcs_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
        .close_cmd_i(close_cmd), .bypass_i(bypass_i), .meas0_i(meas0), .meas1_i(meas1),
        .req_o(req_o), .ok_o(ok_o), .fail_o(fail_o), .close_cb_o(close_cb_o));
    // ==========
    // Tasks
    task automatic conclude();
        if (failures == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic over();
        failures++;
        conclude();
    endtask : over
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Read data is taken at the rising edge that samples ack high; only then is the request released.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1 || err_o === 1'b1) break;
        end
        if (n == 20) over();
        rq = dat_o;
        re = err_o;
        {cyc_i, stb_i} <= 2'b00;
    endtask : wb
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask : settle
    task automatic pulse(input logic [1:0] g);
        @(posedge clk_i);
        go <= g;
        @(posedge clk_i);
        go <= 2'b00;
    endtask : pulse
    function automatic logic hit(input int s);
        return s == 2 ? fail_o[0] === 1'b1 : close_cb_o[2*s +: 2] !== 2'b00;
    endfunction : hit
    task automatic await(input int s, input int lim);
        int n;
        for (n = 0; n < lim && !hit(s); n++) @(negedge clk_i);
        if (n == lim) over();
    endtask : await
    // ==========
    // Sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        settle(0);
        chk("outputs", {req_o, ok_o, fail_o, close_cb_o}, 32'h0);
        wb(1'b0, `BCS_ADR_CTRL0, 32'h0);
        chk("ctrl0", rq, `BCS_CTL_RST);
        wb(1'b0, `BCS_ADR_TMO1, 32'h0);
        chk("tmo1", rq, `BCS_TMO_RST);
        wb(1'b0, `BCS_ADR_ADV0, 32'h0);
        chk("adv0", rq, `BCS_ADV_RST);
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped", re, 1'b1);
        foreach (rows[i]) begin
            wb(1'b1, `BCS_ADR_CTRL0, {23'h0, rows[i].ctl});
            wb(1'b1, `BCS_ADR_CTRL1, {23'h0, rows[i].ctl});
            meas_set <= rows[i].meas;
            bypass_i <= {2{rows[i].byp}};
            settle(4);
            chk("ok", ok_o, {2{rows[i].ok}});
            wb(1'b0, `BCS_ADR_STAT, 32'h0);
            chk("stat", rq, {26'h0, 2'b00, {2{rows[i].ok}}, 2'b00});
        end
        wb(1'b1, `BCS_ADR_CTRL1, 32'h148);
        meas_set <= 8'h5c;
        bypass_i <= 2'b00;
        pulse(2'b01);
        settle(2);
        chk("req wait", req_o, 2'b01);
        @(posedge clk_i);
        meas_set <= 8'h5e;
        await(0, 20);
        chk("close0", close_cb_o, 4'h1);
        chk("req end", req_o[0], 1'b0);
        pulse(2'b10);
        await(1, 20);
        chk("close1", close_cb_o[3:2], 2'b10);
        chk("req1", req_o[1], 1'b0);
        wb(1'b1, `BCS_ADR_CTRL0, 32'h108);
        meas_set <= 8'h5c;
        pulse(2'b01);
        await(0, 20);
        chk("no breaker", close_cb_o[1:0], 2'b11);
        wb(1'b1, `BCS_ADR_ADV0, 32'h1);
        wb(1'b1, `BCS_ADR_CTRL0, 32'h130);
        meas_set <= 8'h5e;
        pulse(2'b01);
        @(posedge clk_i);
        meas_set <= 8'h5f;
        settle(4);
        chk("zero lead", {req_o[0], close_cb_o[1:0]}, 3'b100);
        await(0, 45000);
        chk("zero close", close_cb_o[1:0], 2'b01);
        wb(1'b1, `BCS_ADR_CTRL0, 32'h128);
        meas_set <= 8'h5c;
        wb(1'b1, `BCS_ADR_TMO0, 32'h1);
        wb(1'b1, `BCS_ADR_CMD, 32'h1);
        settle(2);
        chk("req cmd", req_o[0], 1'b1);
        await(2, 45000);
        chk("req timeout", req_o[0], 1'b0);
        settle(8);
        chk("fail held", fail_o[0], 1'b1);
        wb(1'b0, `BCS_ADR_STAT, 32'h0);
        chk("stat fail", rq[4], 1'b1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        settle(1);
        chk("fail reset", fail_o, 2'b00);
        wb(1'b0, `BCS_ADR_TMO0, 32'h0);
        chk("tmo0 reset", rq, `BCS_TMO_RST);
        conclude();
    end
endmodule : test_bcs_top
